// [ts_serial_input_acquisition.sv]
/*
 ts_serial_input_acquisition: serial transport-stream input front end.
 Source select, security-module loop, serial/parallel conversion, acquisition
 memory with packet-relative write counter, scrambling-control decode and a
 27 MHz time stamp. Assumes a 50 MHz ref_clk, pins asynchronous to it,
 and an AHB-Lite master doing single word transfers.
*/
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
// How it works
// [R01] source holds framing high for exactly 1504 or 1040 significant bits
// [R02] framing rising edge resets the acquisition write counter: new packet
// [R03] packet flagged errored is dropped whole, never written to memory
// [R04] source keeps error steady over the packet, changing it at framing edges
// [R05] program-stream sector start rising edge marks packet start, resets counter
// [R06] program-stream data-valid comes in bursts of at least eight bits
// [R07] bits assemble into bytes, written only while data-valid is high
// [R08] input accepts up to 59.5 Mbit/s; descrambler clock is 60 MHz; pins here are sampled on the 50 MHz ref_clk
// [R09] two software selectors: FEC or link input, security loop or bypass
// [R10] conversion follows the loop; software picks first bit as MSB or LSB
// [R11] loop input shifts bits into a byte, toggles a flag per byte
// [R12] bytes leave on system clock; module clock stays low when nothing waits
// [R13] data to the security module changes on the module clock rising edge
// [R14] returning stream finds packet start by sync byte 0x47, makes framing
// [R15] 130-byte packets get a sync byte prepended, stripped on return
// [R16] link input is resynchronised and given a bit strobe and data-valid
// [R17] FEC bit clock must stay below the system clock rate
// [R18] software sets the upper limit at which the write counter wraps
// [R19] software programs limit 44, 63, 53 or 58 depending on the mode
// [R20] scrambling control decoded from byte 4, byte 11, or byte 1 inverted
// [R21] PES payload tracked in 184-byte blocks with a remainder count
// [R22] free-running 27 MHz stamp and 12 extra bits offered to link transmit
// [R23] FEC data sampled on the falling edge of the FEC bit clock
// [R24] acquisition memory of 64 bytes between pin timing and software reads
// [R25] byte flag passes a two-stage path with edge detection before use
`default_nettype none
module ts_serial_input_acquisition
   import ts_acq_pkg::*;
#(
   parameter int STAMP_W = 20
) (
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rst_b,
   // AHB-Lite slave
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   // FEC serial input
   input  wire logic               fec_bit_clk,
   input  wire logic               fec_data,
   input  wire logic               fec_frame,
   input  wire logic               fec_flag,
   // high-speed link input
   input  wire logic               link_clk,
   input  wire logic               link_data,
   input  wire logic               link_valid,
   // security module loop
   output logic                    sm_clk,
   output logic                    sm_data,
   input  wire logic               sm_ret_clk,
   input  wire logic               sm_ret_data,
   // link transmit tagging
   output logic      [STAMP_W-1:0] tx_stamp,
   output logic      [11:0]        tx_extra
);
   import ts_acq_pkg::*;

   localparam int AW = 6;

   typedef struct packed {
      logic [8:0]  s1;
      logic [8:0]  s2;
      logic [8:0]  s3;
      logic        src_link;
      logic        sm_en;
      logic        lsb_first;
      mode_t       mode;
      logic [5:0]  limit;
      logic [11:0] extra;
      logic [7:0]  baddr;
      logic        bwr;
      logic        brd_data;
      logic        rd_ok;
      logic [31:0] rd_word;
      logic        frm_prev;
      logic        flg_prev;
      logic        err;
      logic [7:0]  csh;
      logic [2:0]  ccnt;
      logic [7:0]  ihold;
      logic        itog;
      logic        itog_q;
      logic        iseen;
      logic        ins_sync;
      tx_state_t   tx;
      logic [7:0]  tsh;
      logic [2:0]  tcnt;
      logic        sm_clk;
      logic        sm_data;
      ret_state_t  rs;
      logic [7:0]  rsh;
      logic [2:0]  rcnt;
      logic [7:0]  rbytes;
      logic        rlock;
      logic [5:0]  wptr;
      logic [5:0]  rptr;
      logic [11:0] idx;
      logic [7:0]  drops;
      logic [1:0]  tp_sc;
      logic [1:0]  pes_sc;
      logic [7:0]  pes_pos;
      logic [15:0] pes_blk;
      logic [6:0]  acc;
      logic [31:0] stamp;
   } acq_state_t;

   acq_state_t st_reg;
   acq_state_t st_next;

   acq_ram_if #(.AW(AW), .DW(8)) ram ();

   acq_ram #(.AW(AW), .DW(8)) u_ram (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .port    (ram.mem)
   );

   function automatic logic [7:0] pkt_len(input mode_t m);
      pkt_len = (m == MODE_TS130) ? PKT_LEN_130S : PKT_LEN_188;
   endfunction

   function automatic logic [7:0] bit_rev(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         bit_rev[i] = b[7-i];
      end
   endfunction

   logic       fclk_fall;
   logic       lclk_rise;
   logic       rclk_fall;
   logic       bit_stb;
   logic       bit_d;
   logic       frm;
   logic       flg;
   logic       ps;
   logic       in_start;
   logic       err_now;
   logic [2:0] cnt_in;
   logic [7:0] byte_in;
   logic       dir_done;
   logic       avail;
   logic [7:0] rsh_new;
   logic       ret_start;
   logic       ret_stb;
   logic       pkt_start;
   logic       byte_stb;
   logic [7:0] byte_raw;
   logic [7:0] wbyte;
   logic [5:0] wbase;
   logic [11:0] idx1;
   logic [6:0] level;
   logic       bus_acc;
   logic       pop;
   logic [6:0] acc_sum;

   always_comb begin
      st_next = st_reg;
      // [R08] two-flop resync of every pin, third stage for edges
      st_next.s1 = {sm_ret_data, sm_ret_clk, link_valid, link_data, link_clk,
                    fec_flag, fec_frame, fec_data, fec_bit_clk};
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // [R23] FEC falling edge sampling
      fclk_fall = st_reg.s3[0] & ~st_reg.s2[0];
      // [R16] link resync to bit strobe
      lclk_rise = ~st_reg.s3[4] & st_reg.s2[4];
      rclk_fall = st_reg.s3[7] & ~st_reg.s2[7];
      // [R09] input source selector
      bit_stb = st_reg.src_link ? (lclk_rise & st_reg.s2[6]) : fclk_fall;
      bit_d   = st_reg.src_link ? st_reg.s2[5] : st_reg.s2[1];
      frm     = st_reg.src_link ? st_reg.s2[6] : st_reg.s2[2];
      flg     = st_reg.src_link ? 1'b0 : st_reg.s2[3];
      ps      = st_reg.mode[1];
      if (st_reg.src_link ? lclk_rise : bit_stb) begin
         st_next.frm_prev = frm;
         st_next.flg_prev = flg;
      end
      // [R02] framing edge starts packet
      // [R05] sector start edge starts packet
      if (ps && !st_reg.src_link) begin
         in_start = bit_stb & flg & ~st_reg.flg_prev;
      end else begin
         in_start = bit_stb & frm & ~st_reg.frm_prev;
      end
      // [R03] error latched per packet
      err_now = in_start ? (~ps & flg) : st_reg.err;
      st_next.err = err_now;
      // [R06] [R07] bytes built only while valid
      cnt_in   = in_start ? 3'h0 : st_reg.ccnt;
      byte_in  = {st_reg.csh[6:0], bit_d};
      dir_done = bit_stb & frm & (cnt_in == 3'h7);
      if (in_start) begin
         st_next.ccnt = 3'h0;
      end
      if (bit_stb && frm) begin
         st_next.csh  = byte_in;
         st_next.ccnt = cnt_in + 3'h1;
      end
      // [R11] byte flag toggles per byte
      if (st_reg.sm_en && dir_done) begin
         st_next.ihold = byte_in;
         st_next.itog  = ~st_reg.itog;
      end
      // [R25] flag delayed then edge compared
      st_next.itog_q = st_reg.itog;
      avail = st_reg.itog_q ^ st_reg.iseen;
      // [R12] shift out, clock low when idle
      case (st_reg.tx)
         TX_IDLE: begin
            st_next.sm_clk = 1'b0;
            st_next.tcnt   = 3'h0;
            if (st_reg.ins_sync) begin
               st_next.tsh      = SYNC_BYTE;
               st_next.ins_sync = 1'b0;
               st_next.tx       = TX_LOW;
            end else if (avail) begin
               st_next.tsh   = st_reg.ihold;
               st_next.iseen = st_reg.itog_q;
               st_next.tx    = TX_LOW;
            end
         end
         TX_LOW: begin
            // [R13] data moves with clock rise
            st_next.sm_clk  = 1'b1;
            st_next.sm_data = st_reg.tsh[7];
            st_next.tx      = TX_HIGH;
         end
         TX_HIGH: begin
            st_next.sm_clk = 1'b0;
            st_next.tsh    = {st_reg.tsh[6:0], 1'b0};
            st_next.tcnt   = st_reg.tcnt + 3'h1;
            st_next.tx     = (st_reg.tcnt == 3'h7) ? TX_IDLE : TX_LOW;
         end
         default: begin
            st_next.sm_clk = 1'b0;
            st_next.tx     = TX_IDLE;
         end
      endcase
      // [R15] sync byte prepended; set wins over clear
      if (st_reg.sm_en && in_start && st_reg.mode == MODE_TS130) begin
         st_next.ins_sync = 1'b1;
      end
      // [R14] sync hunt on returning stream
      rsh_new   = {st_reg.rsh[6:0], st_reg.s2[8]};
      ret_start = 1'b0;
      ret_stb   = 1'b0;
      case (st_reg.rs)
         RET_HUNT: begin
            st_next.rlock = 1'b0;
            if (rclk_fall) begin
               st_next.rsh = rsh_new;
               if (rsh_new == SYNC_BYTE) begin
                  st_next.rs     = RET_LOCK;
                  st_next.rlock  = 1'b1;
                  st_next.rcnt   = 3'h0;
                  st_next.rbytes = 8'h01;
                  ret_start      = 1'b1;
                  // [R15] sync stripped for 130-byte packets
                  ret_stb        = (st_reg.mode != MODE_TS130);
               end
            end
         end
         RET_LOCK: begin
            if (rclk_fall) begin
               st_next.rsh  = rsh_new;
               st_next.rcnt = st_reg.rcnt + 3'h1;
               if (st_reg.rcnt == 3'h7) begin
                  ret_stb        = 1'b1;
                  st_next.rbytes = st_reg.rbytes + 8'h01;
                  if (st_reg.rbytes + 8'h01 == pkt_len(st_reg.mode)) begin
                     st_next.rs = RET_HUNT;
                  end
               end
            end
         end
         default: begin
            st_next.rs = RET_HUNT;
         end
      endcase
      // [R10] conversion after the loop
      if (st_reg.sm_en) begin
         pkt_start = ret_start;
         byte_stb  = ret_stb & ~st_reg.err;
         byte_raw  = rsh_new;
      end else begin
         pkt_start = in_start;
         byte_stb  = dir_done & ~err_now;
         byte_raw  = byte_in;
      end
      wbyte = st_reg.lsb_first ? bit_rev(byte_raw) : byte_raw;
      if (in_start && err_now) begin
         st_next.drops = st_reg.drops + 8'h01;
      end
      // [R02] counter reset at packet start
      wbase = pkt_start ? 6'h00 : st_reg.wptr;
      idx1  = (pkt_start ? 12'h000 : st_reg.idx) + 12'h001;
      if (pkt_start) begin
         st_next.wptr = 6'h00;
         st_next.idx  = 12'h000;
      end
      ram.we    = byte_stb;
      ram.waddr = wbase;
      ram.wdata = wbyte;
      if (byte_stb) begin
         // [R18] wrap at the programmed limit
         st_next.wptr = (wbase == st_reg.limit) ? 6'h00 : wbase + 6'h01;
         st_next.idx  = idx1;
         // [R20] scrambling control decode
         if (st_reg.mode == MODE_TS130 && idx1 == SC_130_IDX) begin
            st_next.tp_sc = {~wbyte[5], wbyte[4]};
         end
         if (st_reg.mode == MODE_TS188 && idx1 == SC_TP_IDX) begin
            st_next.tp_sc = wbyte[7:6];
         end
         if (st_reg.mode == MODE_TS188 && idx1 == SC_PES_IDX) begin
            st_next.pes_sc = wbyte[5:4];
            if (!wbyte[5]) begin
               st_next.pes_pos = 8'h00;
               st_next.pes_blk = 16'h0000;
            end
         end
         // [R21] 184-byte PES payload blocks
         if (st_reg.pes_sc[1] && idx1 > SC_TP_IDX) begin
            if (st_reg.pes_pos == PES_BLOCK - 8'h01) begin
               st_next.pes_pos = 8'h00;
               st_next.pes_blk = st_reg.pes_blk + 16'h0001;
            end else begin
               st_next.pes_pos = st_reg.pes_pos + 8'h01;
            end
         end
      end
      // [R24] fill level of the 64-byte store
      if (st_reg.wptr >= st_reg.rptr) begin
         level = {1'b0, st_reg.wptr} - {1'b0, st_reg.rptr};
      end else begin
         level = {1'b0, st_reg.wptr} + {1'b0, st_reg.limit} + 7'h01 - {1'b0, st_reg.rptr};
      end
      // bus address phase
      bus_acc = hsel & hready & htrans[1];
      pop     = bus_acc & ~hwrite & (haddr[7:0] == ADDR_DATA) & (level != 7'h00);
      ram.raddr        = st_reg.rptr;
      st_next.bwr      = bus_acc & hwrite;
      st_next.brd_data = bus_acc & ~hwrite & (haddr[7:0] == ADDR_DATA);
      st_next.rd_ok    = pop;
      if (bus_acc) begin
         st_next.baddr = haddr[7:0];
      end
      if (pop) begin
         st_next.rptr = (st_reg.rptr == st_reg.limit) ? 6'h00 : st_reg.rptr + 6'h01;
      end
      // unread bytes of the old packet are lost at a new start
      if (pkt_start) begin
         st_next.rptr = 6'h00;
      end
      if (st_reg.brd_data) begin
         st_next.rd_word = hrdata;
      end
      if (bus_acc && !hwrite) begin
         case (haddr[7:0])
            ADDR_CTRL:     st_next.rd_word = {27'h0, st_reg.mode, st_reg.lsb_first,
                                              st_reg.sm_en, st_reg.src_link};
            ADDR_LIMIT:    st_next.rd_word = {26'h0, st_reg.limit};
            ADDR_STATUS:   st_next.rd_word = {st_reg.drops, 7'h0, st_reg.rlock,
                                              1'b0, level, 2'h0, st_reg.wptr};
            ADDR_SCRAMBLE: st_next.rd_word = {st_reg.pes_blk, st_reg.pes_pos, 4'h0,
                                              st_reg.pes_sc, st_reg.tp_sc};
            ADDR_EXTRA:    st_next.rd_word = {20'h0, st_reg.extra};
            ADDR_STAMP:    st_next.rd_word = st_reg.stamp;
            default:       st_next.rd_word = 32'h0000_0000;
         endcase
      end
      // bus data phase writes
      if (st_reg.bwr) begin
         case (st_reg.baddr)
            ADDR_CTRL: begin
               // [R09] source and loop selectors
               st_next.src_link  = hwdata[CTRL_SRC_BIT];
               st_next.sm_en     = hwdata[CTRL_SM_BIT];
               // [R10] bit order control
               st_next.lsb_first = hwdata[CTRL_LSB_BIT];
               st_next.mode      = mode_t'(hwdata[CTRL_MODE_LO+1:CTRL_MODE_LO]);
            end
            ADDR_LIMIT: st_next.limit = hwdata[5:0];
            ADDR_EXTRA: st_next.extra = hwdata[11:0];
            default: begin
            end
         endcase
      end
      // [R22] free-running 27 MHz stamp by rate accumulator
      acc_sum = st_reg.acc + STAMP_INC;
      if (acc_sum >= STAMP_MOD) begin
         st_next.acc   = acc_sum - STAMP_MOD;
         st_next.stamp = st_reg.stamp + 32'h0000_0001;
      end else begin
         st_next.acc = acc_sum;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg       <= '0;
         st_reg.mode  <= MODE_TS188;
         st_reg.tx    <= TX_IDLE;
         st_reg.rs    <= RET_HUNT;
         st_reg.limit <= LIMIT_RST;
         st_reg.extra <= EXTRA_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign hrdata    = st_reg.brd_data ? {23'h0, st_reg.rd_ok, ram.rdata} : st_reg.rd_word;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign sm_clk    = st_reg.sm_clk;
   assign sm_data   = st_reg.sm_data;
   assign tx_stamp  = st_reg.stamp[STAMP_W-1:0];
   assign tx_extra  = st_reg.extra;
endmodule
`default_nettype wire

// [ts_acq_pkg.sv]
/*
 ts_acq_pkg: register offsets, reset values, field positions, stream constants
 and state encodings for the serial transport-stream acquisition front end.
 Assumes a single 50 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package ts_acq_pkg;
   // clocks and rates
   localparam int SYS_CLK_HZ        = 50_000_000;
   localparam int STAMP_CLK_HZ      = 27_000_000;
   localparam int SYS_CLK_MHZ       = SYS_CLK_HZ / 1_000_000;
   localparam int STAMP_CLK_MHZ     = STAMP_CLK_HZ / 1_000_000;
   localparam logic [6:0] STAMP_INC = 7'(STAMP_CLK_MHZ);
   localparam logic [6:0] STAMP_MOD = 7'(SYS_CLK_MHZ);
   localparam int BIT_RATE_MAX_KBPS = 59_500;
   localparam int DESCR_CLK_MHZ     = 60;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_LIMIT    = 8'h04;
   localparam logic [7:0] ADDR_STATUS   = 8'h08;
   localparam logic [7:0] ADDR_SCRAMBLE = 8'h0C;
   localparam logic [7:0] ADDR_EXTRA    = 8'h10;
   localparam logic [7:0] ADDR_STAMP    = 8'h14;
   localparam logic [7:0] ADDR_DATA     = 8'h18;

   // control field positions
   localparam int CTRL_SRC_BIT  = 0;
   localparam int CTRL_SM_BIT   = 1;
   localparam int CTRL_LSB_BIT  = 2;
   localparam int CTRL_MODE_LO  = 3;

   // reset values
   localparam logic [5:0]  LIMIT_RST = 6'h3F;
   localparam logic [11:0] EXTRA_RST = 12'h000;

   // stream constants
   localparam logic [7:0]  SYNC_BYTE     = 8'h47;
   localparam logic [7:0]  PKT_LEN_188   = 8'hBC;
   localparam logic [7:0]  PKT_LEN_130S  = 8'h83;
   localparam logic [7:0]  PES_BLOCK     = 8'hB8;
   localparam logic [11:0] SC_TP_IDX     = 12'h004;
   localparam logic [11:0] SC_PES_IDX    = 12'h00B;
   localparam logic [11:0] SC_130_IDX    = 12'h001;

   // modes and states
   typedef enum logic [1:0] {
      MODE_TS188 = 2'b00,
      MODE_TS130 = 2'b01,
      MODE_PS    = 2'b10,
      MODE_CD    = 2'b11
   } mode_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_LOW  = 2'b01,
      TX_HIGH = 2'b11
   } tx_state_t;

   typedef enum logic [0:0] {
      RET_HUNT = 1'b0,
      RET_LOCK = 1'b1
   } ret_state_t;
endpackage
`default_nettype wire

// [acq_ram_if.sv]
/*
 acq_ram_if: write and read port of the acquisition memory.
 Assumes both ends run on the system clock.
*/
`default_nettype none
interface acq_ram_if #(parameter int AW = 6, parameter int DW = 8);
   logic          we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [acq_ram.sv]
/*
 acq_ram: small acquisition memory, one write and one read port, read data
 registered. Assumes addresses are in range and one clock for both ports.
*/
`default_nettype none
module acq_ram #(
   parameter int AW = 6,
   parameter int DW = 8
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // memory port
   acq_ram_if.mem    port
);
   localparam int DEPTH = 1 << AW;

   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;
      logic [DW-1:0]            rdata;
   } ram_state_t;

   ram_state_t st_reg;
   ram_state_t st_next;

   always_comb begin
      st_next = st_reg;
      // read sees the old word when it meets a write
      st_next.rdata = st_reg.mem[port.raddr];
      if (port.we) begin
         st_next.mem[port.waddr] = port.wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign port.rdata = st_reg.rdata;
endmodule
`default_nettype wire

// [ts_acq_sva.sv]
/* ts_acq_sva: port assertions for the acquisition front end.
   assumes one ref_clk domain; bound to the top module at the foot */
`default_nettype none
module ts_acq_sva #(parameter int STAMP_W = 20) (
   // clock and reset
   input wire logic               ref_clk,
   input wire logic               rst_b,
   // register bus
   input wire logic               hsel,
   input wire logic [31:0]        haddr,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic               hready,
   input wire logic [31:0]        hrdata,
   input wire logic               hreadyout,
   input wire logic               hresp,
   // loop and tagging
   input wire logic               sm_clk,
   input wire logic               sm_data,
   input wire logic [STAMP_W-1:0] tx_stamp,
   input wire logic [11:0]        tx_extra
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   logic take;
   logic wext;
   assign take = hsel && hready && htrans[1];
   assign wext = take && hwrite && haddr[7:0] == ts_acq_pkg::ADDR_EXTRA;
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_ready_high: assert property (hreadyout == 1'b1)
      else $error("wait state inserted");
   a_rdata_hold: assert property (!take |=> $stable(hrdata))
      else $error("read data moved outside a transfer");
   a_smclk_pulse: assert property (sm_clk |=> !sm_clk)
      else $error("module clock high two cycles");
   a_smdata_edge: assert property ($changed(sm_data) |-> $rose(sm_clk))
      else $error("module data moved off the clock rise");
   a_extra_write: assert property ($changed(tx_extra) |-> $past(wext, 2))
      else $error("extra bits changed without a write");
   a_stamp_step: assert property (STAMP_W'(tx_stamp - $past(tx_stamp)) <= 1)
      else $error("stamp jumped");
   a_stamp_moves: assert property ($stable(tx_stamp) |-> ##[1:2] $changed(tx_stamp))
      else $error("stamp stalled");
   c_sm_bit: cover property ($rose(sm_clk));
   c_write: cover property (take && hwrite);
   c_read: cover property (take && !hwrite);
endmodule
bind ts_serial_input_acquisition ts_acq_sva #(.STAMP_W(STAMP_W)) sva_u (
   .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .sm_clk(sm_clk), .sm_data(sm_data), .tx_stamp(tx_stamp),
   .tx_extra(tx_extra));
`default_nettype wire

// [fec_src.sv]
/* fec_src: behavioural channel-chip source on the serial pins.
   assumes send is called off the ref_clk edge; bit clock rests low between packets */
`default_nettype none
module fec_src (
   // serial pins
   output var logic fclk,
   output var logic fdat,
   output var logic frm,
   output var logic flg
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      fclk = 1'b0;
      fdat = 1'b0;
      frm = 1'b0;
      flg = 1'b0;
   end
   // 160 ns bit period, slower than ref_clk; data moves at the rise
   task automatic tick(input logic d, input logic v, input logic f);
      fclk = 1'b1;
      fdat = d;
      frm = v;
      flg = f;
      #80 fclk = 1'b0;
      #80;
   endtask
   task automatic send(input int n, input bit ps, input bit err, input logic [7:0] b0);
      logic [7:0] b;
      for (int i = 0; i < n; i++) begin
         b = b0 + 8'(i);
         // framing on every bit, error steady, start on first bit
         for (int k = 7; k >= 0; k--) tick(b[k], 1'b1, ps ? (i == 0 && k == 7) : err);
         // whole bytes only, idle cycle between bursts
         if (ps) tick(~b[0], 1'b0, 1'b0);
      end
      // released data shows the inverse, never a held value
      tick(~b[0], 1'b0, ps ? 1'b0 : err);
   endtask
endmodule
`default_nettype wire

// [ts_serial_input_acquisition_tb.sv]
/* ts_serial_input_acquisition_tb: packet table through the serial pins, registers
   over AHB-Lite. assumes the security loop is closed by plain wires */
`default_nettype none
module ts_serial_input_acquisition_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ts_acq_pkg::*;
   typedef struct {logic [31:0] ctrl; logic [31:0] lim; logic [7:0] n; bit err;
      logic [31:0] wp;} row_t;
   logic        ref_clk, rst_b, hsel, hwrite, hready, hresp, sm_clk, sm_data;
   logic        fclk, fdat, frm, flg;
   logic [31:0] haddr, hwdata, hrdata, rd, failures, checked, drops, sm_cnt;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  b;
   logic [19:0] tx_stamp;
   logic [11:0] tx_extra;
   row_t rows [5] = '{
      '{32'h00, 32'h3F, PKT_LEN_188, 1'b0, 32'h3C},
      '{32'h00, 32'h2B, PKT_LEN_188, 1'b0, 32'h0C},
      '{32'h00, 32'h3F, PKT_LEN_188, 1'b1, 32'h00},
      '{32'h08, 32'h2C, 8'h82, 1'b0, 32'h28},
      '{32'h09, 32'h3F, 8'h82, 1'b0, 32'h02}};
   ts_serial_input_acquisition #(.STAMP_W(20)) dut_u (
      .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .fec_bit_clk(fclk), .fec_data(fdat),
      .fec_frame(frm), .fec_flag(flg), .link_clk(fclk), .link_data(fdat),
      .link_valid(frm), .sm_clk(sm_clk), .sm_data(sm_data), .sm_ret_clk(sm_clk),
      .sm_ret_data(sm_data), .tx_stamp(tx_stamp), .tx_extra(tx_extra));
   fec_src src_u (.fclk(fclk), .fdat(fdat), .frm(frm), .flg(flg));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge sm_clk) sm_cnt++;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wait_rdy;
      int t;
      t = 0;
      do begin
         @(posedge ref_clk);
         t++;
      end while (hready !== 1'b1 && t < 100);
      if (hready !== 1'b1) begin
         failures++;
         summarize();
      end
   endtask
   // called just after a rising edge; holds each phase until hready is seen
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   initial begin
      rst_b = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      failures = 32'h0;
      checked = 32'h0;
      drops = 32'h0;
      sm_cnt = 32'h0;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      rdchk(ADDR_CTRL, 32'h0); // both selectors clear
      rdchk(ADDR_LIMIT, {26'h0, LIMIT_RST}); // limit at reset
      rdchk(ADDR_EXTRA, 32'h0); // extra bits at reset
      foreach (rows[i]) begin
         bus(1'b1, ADDR_CTRL, rows[i].ctrl);
         bus(1'b1, ADDR_LIMIT, rows[i].lim);
         #5 src_u.send(rows[i].n, 1'b0, rows[i].err, 8'(i));
         drops += 32'(rows[i].err);
         @(posedge ref_clk);
         bus(1'b0, ADDR_STATUS, 32'h0);
         chk({26'h0, rd[5:0]}, rows[i].wp); // write index
         chk({24'h0, rd[31:24]}, drops); // dropped packets
      end
      bus(1'b1, ADDR_EXTRA, 32'hFFFF_FABC);
      rdchk(ADDR_EXTRA, 32'h0000_0ABC); // extra bits kept
      chk({20'h0, tx_extra}, 32'h0000_0ABC); // extra bits offered
      bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
      rdchk(8'h1C, 32'h0); // unmapped place
      for (int lsb = 0; lsb < 2; lsb++) begin
         bus(1'b1, ADDR_CTRL, lsb ? 32'h14 : 32'h10);
         #5 src_u.send(4, 1'b1, 1'b0, 8'hA1);
         @(posedge ref_clk);
         for (int j = 0; j < 5; j++) begin
            b = 8'hA1 + 8'(j);
            if (lsb) b = {<<{b}};
            bus(1'b0, ADDR_DATA, 32'h0);
            chk(j < 4 ? rd : {31'h0, rd[8]}, j < 4 ? {23'h0, 1'b1, b} : 32'h0);
         end
      end
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, ADDR_CTRL, m ? 32'h0A : 32'h02);
         sm_cnt = 32'h0;
         #5 src_u.send(m ? 130 : 188, 1'b0, 1'b0, m ? 8'h10 : SYNC_BYTE);
         repeat (100) @(posedge ref_clk);
         chk(sm_cnt, m ? 32'h418 : 32'h5E0); // bits sent to module
      end
      summarize();
   end
endmodule
`default_nettype wire
